// [hdl/rtc_alarm_pkg.sv]
`default_nettype none

package rtc_alarm_pkg;

  // register offsets
  localparam logic [3:0] OFS_MINUTE_COUNTER = 4'h1;
  localparam logic [3:0] OFS_HOUR_COUNTER = 4'h2;
  localparam logic [3:0] OFS_WEEKDAY_COUNTER = 4'h3;
  localparam logic [3:0] OFS_DATE_COUNTER = 4'h4;
  localparam logic [3:0] OFS_MINUTE_ALARM = 4'h8;
  localparam logic [3:0] OFS_HOUR_ALARM = 4'h9;
  localparam logic [3:0] OFS_WEEKDAY_OR_DATE_ALARM = 4'hA;
  localparam logic [3:0] OFS_EXTENSION_CONTROL = 4'hD;
  localparam logic [3:0] OFS_EVENT_FLAGS = 4'hE;
  localparam logic [3:0] OFS_MAIN_CONTROL = 4'hF;

  // field positions
  localparam int unsigned ALARM_COMPARE_DISABLE_BIT = 7;
  localparam int unsigned WEEKDAY_OR_DATE_SELECT_BIT = 6;
  localparam int unsigned ALARM_FLAG_BIT = 3;
  localparam int unsigned TIMER_EVENT_FLAG_BIT = 4;
  localparam int unsigned UPDATE_EVENT_FLAG_BIT = 5;
  localparam int unsigned LOW_VOLTAGE_FLAG_BIT = 1;
  localparam int unsigned ALARM_IRQ_ENABLE_BIT = 3;
  localparam int unsigned STOP_BIT = 1;
  localparam int unsigned RESET_CTRL_BIT = 0;

  // implemented bit masks; other bits ignore writes and read zero
  localparam logic [7:0] COUNTER_MINUTE_MASK = 8'h7F;
  localparam logic [7:0] COUNTER_HOUR_MASK = 8'h3F;
  localparam logic [7:0] COUNTER_WEEKDAY_MASK = 8'h7F;
  localparam logic [7:0] COUNTER_DATE_MASK = 8'h3F;
  localparam logic [7:0] EXTENSION_MASK = 8'hF3;
  localparam logic [7:0] FLAGS_MASK = 8'h3A;
  localparam logic [7:0] CONTROL_MASK = 8'h3B;

  // reset values
  localparam logic [7:0] ALARM_RESET = 8'h00;
  localparam logic [7:0] EXTENSION_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

endpackage : rtc_alarm_pkg

`default_nettype wire

// [hdl/alarm_match.sv]
`timescale 1ns/1ps
`default_nettype none

// combinational comparison of alarm registers against the time counters
module alarm_match (
  // alarm registers
  input wire logic [7:0] minute_alarm_i,
  input wire logic [7:0] hour_alarm_i,
  input wire logic [7:0] weekday_or_date_alarm_i,
  input wire logic weekday_or_date_select_i,
  // current time
  input wire logic [7:0] minute_i,
  input wire logic [7:0] hour_i,
  input wire logic [7:0] weekday_i,
  input wire logic [7:0] date_i,
  // result
  output logic match_o
);
  import rtc_alarm_pkg::*;

  // a field matches when it is disabled or equal under its mask
  function automatic logic field_hit(input logic [7:0] alarm,
                                     input logic [7:0] now,
                                     input logic [7:0] mask);
    field_hit = alarm[ALARM_COMPARE_DISABLE_BIT] ||
                ((alarm & mask) == (now & mask)); // [R5]
  endfunction : field_hit

  logic min_hit;
  logic hour_hit;
  logic day_hit;

  always_comb begin
    min_hit = field_hit(minute_alarm_i, minute_i, COUNTER_MINUTE_MASK); // [R4]
    hour_hit = field_hit(hour_alarm_i, hour_i, COUNTER_HOUR_MASK); // [R4]
    if (weekday_or_date_alarm_i[ALARM_COMPARE_DISABLE_BIT]) begin
      day_hit = 1'b1; // [R5] [R6]
    end else if (weekday_or_date_select_i) begin
      // date as bcd, weekday view ignored
      day_hit = field_hit(weekday_or_date_alarm_i, date_i,
                          COUNTER_DATE_MASK); // [R2] [R4]
    end else begin
      // any selected weekday bit may hit
      day_hit = |(weekday_or_date_alarm_i & weekday_i &
                  COUNTER_WEEKDAY_MASK); // [R1] [R3]
    end
    match_o = min_hit && hour_hit && day_hit; // [R7]
  end

endmodule : alarm_match

`default_nettype wire

// [hdl/rtc_alarm_match_interrupt.sv]
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// (R1) Select bit 0: shared alarm register is a weekday mask.
// (R2) Select bit 1: shared alarm register is a BCD date.
// (R3) Weekday mode: any set weekday bit among bits 0-6 may match.
// (R4) Minute, hour, date alarms are BCD values compared with counters.
// (R5) A register with its compare-disable bit set is left out.
// (R6) Writing 80h to the day register compares hour and minute only.
// (R7) All three disable bits set: an event every minute.
// (R8) Enabled fields matching the time set the alarm flag.
// (R9) Alarm flag stays 1 until software writes 0.
// (R10) Writing 1 to the alarm flag has no effect.
// (R11) Clearing the flag while the line is low releases it.
// (R12) Enable at 1: event pulls the line low until flag clears.
// (R13) Enable at 0: line not driven; clearing enable releases it.
// (R14) Line is shared; other sources may pull it low.
// (R15) Stop or reset control bit set: no alarm events.
// (R16) Host should clear the enable before programming alarms.
// (R17) Unused alarm registers may be storage with the enable kept 0.
// (R18) Bit 6 of the hour alarm, and of the day alarm in date mode, is free storage.
// (R19) Unused bits of time, flag, control registers read zero.
// (R20) An alarm equal to present time waits for the next advance.
// (R21) Comparison is evaluated once per minute advance.
module rtc_alarm_match_interrupt (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_we_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // timekeeping core
  input wire logic [7:0] minute_i,
  input wire logic [7:0] hour_i,
  input wire logic [7:0] weekday_i,
  input wire logic [7:0] date_i,
  input wire logic minute_advance_i,
  input wire logic update_event_flag_i,
  input wire logic timer_event_flag_i,
  input wire logic low_voltage_flag_i,
  output logic stop_o,
  output logic reset_ctrl_o,
  output logic [7:0] extension_o,
  // open-drain interrupt line
  output logic int_n_o,
  output logic int_n_oe_o
);
  import rtc_alarm_pkg::*;

  logic [7:0] minute_alarm_q;
  logic [7:0] minute_alarm_d;
  logic [7:0] hour_alarm_q;
  logic [7:0] hour_alarm_d;
  logic [7:0] day_alarm_q;
  logic [7:0] day_alarm_d;
  logic [7:0] extension_q;
  logic [7:0] extension_d;
  logic [7:0] control_q;
  logic [7:0] control_d;
  logic alarm_flag_q;
  logic alarm_flag_d;
  logic int_oe_q;
  logic int_oe_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  logic match;
  logic alarm_event;
  logic halted;
  logic flag_wr;

  alarm_match u_match (
    .minute_alarm_i(minute_alarm_q),
    .hour_alarm_i(hour_alarm_q),
    .weekday_or_date_alarm_i(day_alarm_q),
    .weekday_or_date_select_i(extension_q[WEEKDAY_OR_DATE_SELECT_BIT]),
    .minute_i(minute_i),
    .hour_i(hour_i),
    .weekday_i(weekday_i),
    .date_i(date_i),
    .match_o(match)
  );

  // event detection and alarm flag
  always_comb begin
    halted = control_q[STOP_BIT] || control_q[RESET_CTRL_BIT];
    // only a cycle with minute_advance_i high counts, never a held match
    alarm_event = minute_advance_i && match && !halted; // [R15] [R20] [R21]
    flag_wr = reg_we_i && (reg_addr_i == OFS_EVENT_FLAGS);
    alarm_flag_d = alarm_flag_q;
    if (flag_wr && !reg_wdata_i[ALARM_FLAG_BIT]) begin
      alarm_flag_d = 1'b0; // [R9] [R10]
    end
    if (alarm_event) begin
      alarm_flag_d = 1'b1; // [R8]
    end
  end

  // register writes
  always_comb begin
    minute_alarm_d = minute_alarm_q;
    hour_alarm_d = hour_alarm_q;
    day_alarm_d = day_alarm_q;
    extension_d = extension_q;
    control_d = control_q;
    if (reg_we_i) begin
      case (reg_addr_i)
        OFS_MINUTE_ALARM: minute_alarm_d = reg_wdata_i;
        OFS_HOUR_ALARM: hour_alarm_d = reg_wdata_i; // [R18]
        OFS_WEEKDAY_OR_DATE_ALARM: day_alarm_d = reg_wdata_i; // [R18]
        OFS_EXTENSION_CONTROL: extension_d = reg_wdata_i & EXTENSION_MASK;
        OFS_MAIN_CONTROL: control_d = reg_wdata_i & CONTROL_MASK; // [R19]
        default: begin
        end
      endcase
    end
  end

  // interrupt drive and read data
  always_comb begin
    // line held low while flag and enable are both set
    int_oe_d = alarm_flag_d &&
               control_d[ALARM_IRQ_ENABLE_BIT]; // [R11] [R12] [R13] [R14]
    rdata_d = 8'h00;
    case (reg_addr_i)
      OFS_MINUTE_COUNTER: rdata_d = minute_i & COUNTER_MINUTE_MASK; // [R19]
      OFS_HOUR_COUNTER: rdata_d = hour_i & COUNTER_HOUR_MASK; // [R19]
      OFS_WEEKDAY_COUNTER: rdata_d = weekday_i & COUNTER_WEEKDAY_MASK;
      OFS_DATE_COUNTER: rdata_d = date_i & COUNTER_DATE_MASK;
      OFS_MINUTE_ALARM: rdata_d = minute_alarm_q;
      OFS_HOUR_ALARM: rdata_d = hour_alarm_q;
      OFS_WEEKDAY_OR_DATE_ALARM: rdata_d = day_alarm_q;
      OFS_EXTENSION_CONTROL: rdata_d = extension_q;
      OFS_EVENT_FLAGS: begin
        rdata_d[UPDATE_EVENT_FLAG_BIT] = update_event_flag_i;
        rdata_d[TIMER_EVENT_FLAG_BIT] = timer_event_flag_i;
        rdata_d[ALARM_FLAG_BIT] = alarm_flag_q; // [R9]
        rdata_d[LOW_VOLTAGE_FLAG_BIT] = low_voltage_flag_i; // [R19]
      end
      OFS_MAIN_CONTROL: rdata_d = control_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      minute_alarm_q <= ALARM_RESET;
      hour_alarm_q <= ALARM_RESET;
      day_alarm_q <= ALARM_RESET;
      extension_q <= EXTENSION_RESET;
      control_q <= CONTROL_RESET;
      alarm_flag_q <= 1'b0;
      int_oe_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      minute_alarm_q <= minute_alarm_d;
      hour_alarm_q <= hour_alarm_d;
      day_alarm_q <= day_alarm_d;
      extension_q <= extension_d;
      control_q <= control_d;
      alarm_flag_q <= alarm_flag_d;
      int_oe_q <= int_oe_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign stop_o = control_q[STOP_BIT];
  assign reset_ctrl_o = control_q[RESET_CTRL_BIT];
  assign extension_o = extension_q;
  assign int_n_o = 1'b0;
  assign int_n_oe_o = int_oe_q;

  // field comparisons rebuilt from the register layout for the checks
  logic minute_ok;
  logic hour_ok;
  logic date_equal;
  logic weekday_any;

  always_comb begin
    minute_ok = minute_alarm_q[ALARM_COMPARE_DISABLE_BIT] ||
      (((minute_alarm_q ^ minute_i) & COUNTER_MINUTE_MASK) == 8'h00);
    hour_ok = hour_alarm_q[ALARM_COMPARE_DISABLE_BIT] ||
      (((hour_alarm_q ^ hour_i) & COUNTER_HOUR_MASK) == 8'h00);
    date_equal = ((day_alarm_q ^ date_i) & COUNTER_DATE_MASK) == 8'h00;
    weekday_any = (day_alarm_q & weekday_i & COUNTER_WEEKDAY_MASK) != 8'h00;
  end

  // checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  AST_WEEKDAY_ANY: assert property ( // [R3]
    (minute_advance_i && !halted && !extension_q[WEEKDAY_OR_DATE_SELECT_BIT]
     && !minute_alarm_q[ALARM_COMPARE_DISABLE_BIT]
     && !hour_alarm_q[ALARM_COMPARE_DISABLE_BIT]
     && !day_alarm_q[ALARM_COMPARE_DISABLE_BIT]
     && !weekday_any)
    |=> !$rose(alarm_flag_q))
    else $error("weekday mismatch raised the alarm flag");

  AST_ALL_DISABLED: assert property ( // [R7]
    (minute_advance_i && !halted
     && minute_alarm_q[ALARM_COMPARE_DISABLE_BIT]
     && hour_alarm_q[ALARM_COMPARE_DISABLE_BIT]
     && day_alarm_q[ALARM_COMPARE_DISABLE_BIT])
    |=> alarm_flag_q)
    else $error("all fields disabled but no minute event");

  AST_EVENT_SETS: assert property ( // [R8]
    alarm_event |=> alarm_flag_q
    && (int_n_oe_o == control_q[ALARM_IRQ_ENABLE_BIT]))
    else $error("alarm event did not set the flag");

  AST_FLAG_STICKY: assert property ( // [R9]
    alarm_flag_q && !(flag_wr && !reg_wdata_i[ALARM_FLAG_BIT])
    |=> alarm_flag_q)
    else $error("alarm flag dropped without a zero write");

  AST_WRITE_ONE: assert property ( // [R10]
    !alarm_flag_q && !alarm_event && flag_wr |=> !alarm_flag_q)
    else $error("write to alarm flag set it");

  AST_CLEAR_RELEASES: assert property ( // [R11]
    int_n_oe_o && flag_wr && !reg_wdata_i[ALARM_FLAG_BIT] && !alarm_event
    |=> !int_n_oe_o && !alarm_flag_q)
    else $error("clearing the flag did not release the line");

  AST_HELD_LOW: assert property ( // [R12]
    int_n_oe_o && !reg_we_i |=> int_n_oe_o [*1] ##0 alarm_flag_q)
    else $error("interrupt line released on its own");

  AST_ENABLE_GATES: assert property ( // [R13]
    int_n_oe_o |-> control_q[ALARM_IRQ_ENABLE_BIT] && alarm_flag_q)
    else $error("line driven without enable and flag");

  AST_HALT_BLOCKS: assert property ( // [R15]
    halted && !alarm_flag_q |=> !alarm_flag_q)
    else $error("alarm event while stopped");

  AST_RAM_BIT: assert property ( // [R18]
    reg_we_i && reg_addr_i == OFS_HOUR_ALARM
    |=> hour_alarm_q[6] == $past(reg_wdata_i[6]))
    else $error("hour alarm storage bit not kept");

  AST_ZERO_BITS: assert property ( // [R19]
    reg_addr_i == OFS_MAIN_CONTROL ##1 reg_addr_i == OFS_MAIN_CONTROL
    |=> (reg_rdata_o & ~CONTROL_MASK) == 8'h00)
    else $error("protected control bits read nonzero");

  AST_NEEDS_ADVANCE: assert property ( // [R20] [R21]
    !alarm_flag_q && !minute_advance_i |=> !alarm_flag_q)
    else $error("alarm flag set without a minute advance");

  AST_DATE_HIT: assert property ( // [R2]
    minute_advance_i && !halted && extension_q[WEEKDAY_OR_DATE_SELECT_BIT]
    && minute_ok && hour_ok && !day_alarm_q[ALARM_COMPARE_DISABLE_BIT]
    && date_equal |=> alarm_flag_q)
    else $error("date alarm match did not set the flag");

  AST_DATE_MISS: assert property ( // [R2]
    minute_advance_i && extension_q[WEEKDAY_OR_DATE_SELECT_BIT]
    && !day_alarm_q[ALARM_COMPARE_DISABLE_BIT] && !date_equal
    |=> !$rose(alarm_flag_q))
    else $error("date mismatch raised the alarm flag");

  AST_WEEK_HIT: assert property ( // [R1] [R3]
    minute_advance_i && !halted && !extension_q[WEEKDAY_OR_DATE_SELECT_BIT]
    && minute_ok && hour_ok && !day_alarm_q[ALARM_COMPARE_DISABLE_BIT]
    && weekday_any |=> alarm_flag_q)
    else $error("weekday alarm match did not set the flag");

  AST_MINUTE_MISS: assert property ( // [R4]
    minute_advance_i && !minute_ok |=> !$rose(alarm_flag_q))
    else $error("minute mismatch raised the alarm flag");

  AST_HOUR_MISS: assert property ( // [R4]
    minute_advance_i && !hour_ok |=> !$rose(alarm_flag_q))
    else $error("hour mismatch raised the alarm flag");

  AST_DAY_OFF: assert property ( // [R5] [R6]
    minute_advance_i && !halted && day_alarm_q[ALARM_COMPARE_DISABLE_BIT]
    && minute_ok && hour_ok |=> alarm_flag_q)
    else $error("hour and minute match ignored with day disabled");

  AST_CONTROL_QUIET: assert property ( // [R15]
    stop_o || reset_ctrl_o |=> !$rose(alarm_flag_q))
    else $error("alarm flag rose while stop or reset bit set");

  AST_SET_WINS: assert property ( // [R8]
    alarm_event && flag_wr |=> alarm_flag_q)
    else $error("flag clear in the event cycle lost the event");

  AST_ONE_KEEPS: assert property ( // [R10]
    flag_wr && reg_wdata_i[ALARM_FLAG_BIT] && !alarm_event
    |=> alarm_flag_q == $past(alarm_flag_q))
    else $error("writing one changed the alarm flag");

  AST_ENABLE_RELEASES: assert property ( // [R13]
    int_n_oe_o && reg_we_i && reg_addr_i == OFS_MAIN_CONTROL
    && !reg_wdata_i[ALARM_IRQ_ENABLE_BIT] |=> !int_n_oe_o)
    else $error("clearing the enable did not release the line");

  AST_FLAG_ZERO_BITS: assert property ( // [R19]
    reg_addr_i == OFS_EVENT_FLAGS |=> (reg_rdata_o & ~FLAGS_MASK) == 8'h00)
    else $error("protected flag bits read nonzero");

endmodule : rtc_alarm_match_interrupt

`default_nettype wire

// [dv/host_line.sv]
`timescale 1ns/1ps
`default_nettype none

// host side of the shared interrupt line: pull-up plus another source
module host_line (
  // device pin
  input wire logic int_n_i,
  input wire logic int_n_oe_i,
  // other interrupt source pulling low
  input wire logic other_low_i,
  // resolved line level
  output logic int_line_o
);
  // wired-and with pull-up
  assign int_line_o = ~((int_n_oe_i & ~int_n_i) | other_low_i);
endmodule : host_line

`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb;
  import rtc_alarm_pkg::*;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic we = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] mi = 8'h00, hr = 8'h00, wd = 8'h00, dt = 8'h00;
  logic adv = 1'b0;
  logic lowv = 1'b0;
  logic uef = 1'b0;
  logic tef = 1'b0;
  logic other_low = 1'b0;
  logic stop, rstc, int_n, int_oe, line;
  logic [7:0] ext;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;

  always #25 clock_i = ~clock_i;

  rtc_alarm_match_interrupt rtc_alarm_match_interrupt_i (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
    .reg_we_i(we), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .minute_i(mi), .hour_i(hr), .weekday_i(wd), .date_i(dt),
    .minute_advance_i(adv), .update_event_flag_i(uef),
    .timer_event_flag_i(tef), .low_voltage_flag_i(lowv),
    .stop_o(stop), .reset_ctrl_o(rstc), .extension_o(ext),
    .int_n_o(int_n), .int_n_oe_o(int_oe));

  host_line host_line_i (.int_n_i(int_n), .int_n_oe_i(int_oe),
    .other_low_i(other_low), .int_line_o(line));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk(input string name, input logic [7:0] seen,
                     input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic cyc;
    @(posedge clock_i);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    we = 1'b1;
    cyc();
    we = 1'b0;
    cyc();
  endtask : wr

  task automatic chkr(input logic [3:0] a, input logic [7:0] e);
    addr = a;
    cyc();
    chk($sformatf("reg %h", a), rdata, e);
  endtask : chkr

  task automatic set_t(input logic [7:0] m, h, w, d);
    mi = m;
    hr = h;
    wd = w;
    dt = d;
  endtask : set_t

  task automatic pulse;
    adv = 1'b1;
    cyc();
    adv = 1'b0;
    cyc();
  endtask : pulse

  task automatic t_reset;
    chkr(4'h8, 8'h00);
    chkr(4'hA, 8'h00);
    chkr(4'hD, 8'h00);
    chkr(4'hF, 8'h00);
    chk("line", {7'h00, line}, 8'h01);
  endtask : t_reset

  task automatic t_bits;
    wr(4'hF, 8'h00);
    wr(4'h9, 8'hFF);
    chkr(4'h9, 8'hFF);
    wr(4'hD, 8'hFF);
    chkr(4'hD, 8'hF3);
    chk("ext", ext, 8'hF3);
    wr(4'hF, 8'hFF);
    chkr(4'hF, 8'h3B);
    chk("stop", {6'h00, stop, rstc}, 8'h03);
    set_t(8'hFF, 8'hFF, 8'hFF, 8'hFF);
    chkr(4'h1, 8'h7F);
    chkr(4'h2, 8'h3F);
    chkr(4'h3, 8'h7F);
    chkr(4'h4, 8'h3F);
    wr(4'hE, 8'hFF);
    lowv = 1'b1;
    chkr(4'hE, 8'h02);
    uef = 1'b1;
    tef = 1'b1;
    chkr(4'hE, 8'h32);
    lowv = 1'b0;
    uef = 1'b0;
    tef = 1'b0;
    wr(4'hF, 8'h00);
    wr(4'hD, 8'h00);
  endtask : t_bits

  task automatic t_week;
    wr(4'h8, 8'h30);
    wr(4'h9, 8'h07);
    wr(4'hA, 8'h05);
    set_t(8'h30, 8'h07, 8'h02, 8'h05);
    pulse();
    chkr(4'hE, 8'h00);
    set_t(8'h30, 8'h07, 8'h04, 8'h01);
    cyc();
    chkr(4'hE, 8'h00);
    wr(4'hF, 8'h08);
    pulse();
    chk("line", {7'h00, line}, 8'h00);
    chkr(4'hE, 8'h08);
  endtask : t_week

  task automatic t_clear;
    wr(4'hE, 8'h08);
    chkr(4'hE, 8'h08);
    chk("line", {7'h00, line}, 8'h00);
    wr(4'hE, 8'h00);
    chkr(4'hE, 8'h00);
    chk("line", {7'h00, line}, 8'h01);
  endtask : t_clear

  task automatic t_date;
    wr(4'hD, 8'h40);
    wr(4'hA, 8'h15);
    set_t(8'h30, 8'h07, 8'h00, 8'h15);
    pulse();
    chkr(4'hE, 8'h08);
    wr(4'hE, 8'h00);
    set_t(8'h30, 8'h07, 8'h7F, 8'h14);
    pulse();
    chkr(4'hE, 8'h00);
  endtask : t_date

  task automatic t_mask;
    wr(4'hA, 8'h80);
    set_t(8'h31, 8'h07, 8'h00, 8'h01);
    pulse();
    chkr(4'hE, 8'h00);
    set_t(8'h30, 8'h08, 8'h00, 8'h01);
    pulse();
    chkr(4'hE, 8'h00);
    set_t(8'h30, 8'h07, 8'h00, 8'h02);
    pulse();
    chkr(4'hE, 8'h08);
    wr(4'hF, 8'h00);
    chk("line", {7'h00, line}, 8'h01);
    chkr(4'hE, 8'h08);
    wr(4'hE, 8'h00);
    pulse();
    chk("line", {7'h00, line}, 8'h01);
    other_low = 1'b1;
    cyc();
    chk("line", {7'h00, line}, 8'h00);
    other_low = 1'b0;
    wr(4'hE, 8'h00);
  endtask : t_mask

  task automatic t_stop;
    wr(4'hF, 8'h02);
    pulse();
    chkr(4'hE, 8'h00);
    wr(4'hF, 8'h01);
    pulse();
    chkr(4'hE, 8'h00);
    wr(4'hF, 8'h00);
  endtask : t_stop

  task automatic t_every;
    wr(4'h8, 8'h80);
    wr(4'h9, 8'h80);
    set_t(8'h45, 8'h23, 8'h00, 8'h09);
    pulse();
    chkr(4'hE, 8'h08);
    wr(4'hE, 8'h00);
    set_t(8'h46, 8'h23, 8'h00, 8'h09);
    pulse();
    chkr(4'hE, 8'h08);
    addr = 4'hE;
    wdata = 8'h00;
    we = 1'b1;
    adv = 1'b1;
    cyc();
    we = 1'b0;
    adv = 1'b0;
    cyc();
    chkr(4'hE, 8'h08);
  endtask : t_every

  initial begin
    repeat (5) @(posedge clock_i);
    #1;
    sys_rst_i = 1'b0;
    t_reset();
    t_bits();
    t_week();
    t_clear();
    t_date();
    t_mask();
    t_stop();
    t_every();
    give_verdict();
  end
endmodule : tb

`default_nettype wire
